// [common/primary_synth_regs.svh]
// register indices, field positions, reset values and bus codes of the primary synth block
`ifndef PRIMARY_SYNTH_REGS_SVH
`define PRIMARY_SYNTH_REGS_SVH

// register indices (byte address is four times the index)
`define IDX_LOOP_CONTROL   10'h100
`define IDX_PATH_CONFIG    10'h101
`define IDX_PUMP_CURRENT   10'h102
`define IDX_LOOP_FILTER    10'h103

// synth_loop_control bits
`define CTL_CAL_BIT        3
`define CTL_SYNC_BIT       2
`define CTL_PD_BIT         1
`define CTL_RST_BIT        0
`define CTL_RESET          4'h0

// synth_path_config bits
`define PATH_DBL_BIT       3
`define PATH_MODE_HI       2
`define PATH_MODE_LO       1
`define PATH_MOD_PD_BIT    0
`define PATH_RESET         4'h1

// pump_current_setting
`define PUMP_RESET         8'h8d
`define PUMP_UA_SHIFT      2

// loop_filter_setting fields: [7:6] second pole, [5:3] zero, [2:0] first pole
`define FILT_P2_HI         7
`define FILT_P2_LO         6
`define FILT_RZ_HI         5
`define FILT_RZ_LO         3
`define FILT_CP_HI         2
`define FILT_CP_LO         0
`define FILT_RESET         8'he8

// loop mode codes
`define MODE_SINGLE        2'h0
`define MODE_CASCADE       2'h1
`define MODE_FIXED_DELAY   2'h2

// axi responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// [common/primary_synth_pkg.sv]
// types shared by the primary synth configuration block
package primary_synth_pkg;

	// controls driven into the synthesizer analog and divider logic
	typedef struct packed {
		logic       cal_start;         // one-cycle calibration start pulse
		logic       dist_sync;         // hold downstream dividers in sync
		logic       synth_powerdown;   // loop powered down
		logic       synth_reset;       // loop held in reset
		logic       doubler_sel;       // 0 ref_input_divider, 1 doubler
		logic [1:0] loop_mode;         // feedback path select
		logic       modulator_pd;      // feedback_modulator powered down
		logic [7:0] pump_code;         // charge pump code
		logic [9:0] pump_ua;           // charge pump current in microamps
		logic [1:0] second_pole_resistor_code;
		logic [2:0] zero_resistor_code;
		logic [2:0] first_pole_cap_code;
	} synth_ctrl_t;

endpackage

// [design/primary_synth_config_regs.sv]
// axi4-lite register bank for the primary synth loop controls
//
// Contract
// - calibrate bit rising edge starts one calibration
// - sync bit high holds downstream dividers synced
// - path bit selects divider (0) or doubler (1)
// - loop mode selects feedback path; 11 reserved
// - modulator power-down resets to one
// - pump field resets 0x8d; current is 4x
// - zero resistor code resets to five
// - first pole capacitor code resets to zero
`timescale 1ns/1ps
`include "primary_synth_regs.svh"

module primary_synth_config_regs (
	input  wire logic                        clk_in,          // 25 MHz clock
	input  wire logic                        nrst_in,         // async reset, active low
	input  wire logic [11:0]                 awaddr_in,       // write address
	input  wire logic                        awvalid_in,      // write address valid
	output logic                             awready_out,     // write address ready
	input  wire logic [31:0]                 wdata_in,        // write data
	input  wire logic [3:0]                  wstrb_in,        // write byte strobes
	input  wire logic                        wvalid_in,       // write data valid
	output logic                             wready_out,      // write data ready
	output logic [1:0]                       bresp_out,       // write response
	output logic                             bvalid_out,      // write response valid
	input  wire logic                        bready_in,       // write response ready
	input  wire logic [11:0]                 araddr_in,       // read address
	input  wire logic                        arvalid_in,      // read address valid
	output logic                             arready_out,     // read address ready
	output logic [31:0]                      rdata_out,       // read data
	output logic [1:0]                       rresp_out,       // read response
	output logic                             rvalid_out,      // read data valid
	input  wire logic                        rready_in,       // read data ready
	output primary_synth_pkg::synth_ctrl_t   synth_ctrl_out   // controls to the loop
);
	import primary_synth_pkg::*;

	// stored fields
	logic [3:0]  loop_control;     // cal, sync, powerdown, reset
	logic [3:0]  path_config;      // doubler, mode[1:0], modulator pd
	logic [7:0]  pump_current;     // charge pump code
	logic [7:0]  loop_filter;      // filter component codes
	logic [9:0]  pump_ua;          // derived current, registered
	logic        cal_prev;         // last cal bit, for edge detect
	logic        cal_pulse;        // calibration start pulse

	// write channel state
	logic        aw_held;          // address captured
	logic        w_held;           // data captured
	logic [9:0]  aw_index;         // captured word index
	logic [7:0]  w_byte;           // captured low data byte
	logic        w_lane0;          // captured strobe of byte 0
	logic        awready;          // address ready flop
	logic        wready;           // data ready flop
	logic        bvalid;           // response valid flop
	logic [1:0]  bresp;            // response code flop

	// read channel state
	logic        arready;          // read address ready flop
	logic        rvalid;           // read data valid flop
	logic [31:0] rdata;            // read data flop
	logic [1:0]  rresp;            // read response flop

	// handshake and decode wires
	wire         aw_fire   = awvalid_in & awready;
	wire         w_fire    = wvalid_in & wready;
	wire         b_fire    = bvalid & bready_in;
	wire         ar_fire   = arvalid_in & arready;
	wire         r_fire    = rvalid & rready_in;
	wire         wr_go     = aw_held & w_held & ~bvalid;
	wire         sel_ctl   = (aw_index == `IDX_LOOP_CONTROL);
	wire         sel_path  = (aw_index == `IDX_PATH_CONFIG);
	wire         sel_pump  = (aw_index == `IDX_PUMP_CURRENT);
	wire         sel_filt  = (aw_index == `IDX_LOOP_FILTER);
	wire         wr_hit    = sel_ctl | sel_path | sel_pump | sel_filt;
	wire         wr_en     = wr_go & w_lane0;
	wire [9:0]   rd_index  = araddr_in[11:2];
	wire         rd_ctl    = (rd_index == `IDX_LOOP_CONTROL);
	wire         rd_path   = (rd_index == `IDX_PATH_CONFIG);
	wire         rd_pump   = (rd_index == `IDX_PUMP_CURRENT);
	wire         rd_filt   = (rd_index == `IDX_LOOP_FILTER);
	wire         rd_hit    = rd_ctl | rd_path | rd_pump | rd_filt;

	// read mux: narrow registers sit low, reserved and upper bits are zero
	wire [31:0]  rd_word   = rd_ctl  ? {28'h0000000, loop_control} :
	                         rd_path ? {28'h0000000, path_config}  :
	                         rd_pump ? {24'h000000, pump_current}  :
	                         rd_filt ? {24'h000000, loop_filter}   :
	                                   32'h00000000;

	// address phase: held until the response has been taken
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			aw_held  <= 1'b0;
			aw_index <= 10'h000;
			awready  <= 1'b1;
		end
		else if (aw_fire)
		begin
			aw_held  <= 1'b1;
			aw_index <= awaddr_in[11:2];
			awready  <= 1'b0;
		end
		else if (b_fire)
		begin
			aw_held  <= 1'b0;
			awready  <= 1'b1;
		end
	end

	// data phase: taken independently of the address, in either order
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			w_held  <= 1'b0;
			w_byte  <= 8'h00;
			w_lane0 <= 1'b0;
			wready  <= 1'b1;
		end
		else if (w_fire)
		begin
			w_held  <= 1'b1;
			w_byte  <= wdata_in[7:0];
			w_lane0 <= wstrb_in[0];
			wready  <= 1'b0;
		end
		else if (b_fire)
		begin
			w_held  <= 1'b0;
			wready  <= 1'b1;
		end
	end

	// write response once both halves are in; unmapped gets slverr
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (b_fire)
			bvalid <= 1'b0;
	end

	// register storage; only byte lane 0 carries data, reserved bits are dropped
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			loop_control <= `CTL_RESET;
			path_config  <= `PATH_RESET;
			pump_current <= `PUMP_RESET;
			loop_filter  <= `FILT_RESET;
		end
		else if (wr_en)
		begin
			if (sel_ctl)
				loop_control <= w_byte[3:0];
			if (sel_path)
				path_config <= w_byte[3:0];
			if (sel_pump)
				pump_current <= w_byte;
			if (sel_filt)
				loop_filter <= w_byte;
		end
	end

	// calibration start on the low-to-high change of the cal bit only;
	// a bit left at one retriggers nothing until it is cleared again
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cal_prev  <= 1'b0;
			cal_pulse <= 1'b0;
		end
		else
		begin
			cal_prev  <= loop_control[`CTL_CAL_BIT];
			cal_pulse <= loop_control[`CTL_CAL_BIT] & ~cal_prev;
		end
	end

	// pump current in microamps, registered so the output is a flop
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			pump_ua <= {2'b00, `PUMP_RESET} << `PUMP_UA_SHIFT;
		else
			pump_ua <= {2'b00, pump_current} << `PUMP_UA_SHIFT;
	end

	// read channel: one read at a time, data one cycle after the address
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `RESP_OKAY;
		end
		else if (ar_fire)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_word;
			rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (r_fire)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	// bus outputs
	assign awready_out = awready;
	assign wready_out  = wready;
	assign bvalid_out  = bvalid;
	assign bresp_out   = bresp;
	assign arready_out = arready;
	assign rvalid_out  = rvalid;
	assign rdata_out   = rdata;
	assign rresp_out   = rresp;

	// loop controls straight from the stored fields, except cal_start from the edge-detect flop and pump_ua from its flop
	assign synth_ctrl_out.cal_start                 = cal_pulse;
	assign synth_ctrl_out.dist_sync                 = loop_control[`CTL_SYNC_BIT];
	assign synth_ctrl_out.synth_powerdown           = loop_control[`CTL_PD_BIT];
	assign synth_ctrl_out.synth_reset               = loop_control[`CTL_RST_BIT];
	assign synth_ctrl_out.doubler_sel               = path_config[`PATH_DBL_BIT];
	assign synth_ctrl_out.loop_mode                 =
		path_config[`PATH_MODE_HI:`PATH_MODE_LO];
	assign synth_ctrl_out.modulator_pd              = path_config[`PATH_MOD_PD_BIT];
	assign synth_ctrl_out.pump_code                 = pump_current;
	assign synth_ctrl_out.pump_ua                   = pump_ua;
	assign synth_ctrl_out.second_pole_resistor_code = loop_filter[`FILT_P2_HI:`FILT_P2_LO];
	assign synth_ctrl_out.zero_resistor_code        = loop_filter[`FILT_RZ_HI:`FILT_RZ_LO];
	assign synth_ctrl_out.first_pole_cap_code       = loop_filter[`FILT_CP_HI:`FILT_CP_LO];

	// a write that lands in a given register
	sequence s_wr_ctl;
		wr_en && sel_ctl;
	endsequence

	sequence s_wr_path;
		wr_en && sel_path;
	endsequence

	// rising cal bit gives exactly one pulse, two cycles after the write
	property p_cal_rise;
		@(posedge clk_in) disable iff (!nrst_in)
		$rose(loop_control[`CTL_CAL_BIT]) |=> cal_pulse ##1 !cal_pulse;
	endproperty
	a_cal_rise: assert property (p_cal_rise) else $error("cal pulse missing or long");

	// a pulse only ever follows a fresh rise
	property p_cal_cause;
		@(posedge clk_in) disable iff (!nrst_in)
		cal_pulse |-> $past(loop_control[`CTL_CAL_BIT]) && !$past(cal_prev);
	endproperty
	a_cal_cause: assert property (p_cal_cause) else $error("cal pulse without rise");

	// a bit already high and already seen high starts nothing new
	property p_cal_level;
		@(posedge clk_in) disable iff (!nrst_in)
		loop_control[`CTL_CAL_BIT] && cal_prev |=> !cal_pulse;
	endproperty
	a_cal_level: assert property (p_cal_level) else $error("cal pulse on level");

	// sync output takes the written bit after a control write
	property p_sync_write;
		@(posedge clk_in) disable iff (!nrst_in)
		s_wr_ctl |=> synth_ctrl_out.dist_sync == $past(w_byte[`CTL_SYNC_BIT]);
	endproperty
	a_sync_write: assert property (p_sync_write) else $error("sync not written");

	// sync level only moves on a control write, so the dividers stay held
	property p_sync_hold;
		@(posedge clk_in) disable iff (!nrst_in)
		!(wr_en && sel_ctl) |=> $stable(synth_ctrl_out.dist_sync);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync moved without write");

	// doubler select follows the written path bit
	property p_path_write;
		@(posedge clk_in) disable iff (!nrst_in)
		s_wr_path |=> synth_ctrl_out.doubler_sel == $past(w_byte[`PATH_DBL_BIT]);
	endproperty
	a_path_write: assert property (p_path_write) else $error("doubler select wrong");

	// loop mode follows the written field
	property p_mode_write;
		@(posedge clk_in) disable iff (!nrst_in)
		s_wr_path |=> synth_ctrl_out.loop_mode == $past(w_byte[2:1]);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("loop mode wrong");

	// modulator power-down follows the written bit
	property p_modpd_write;
		@(posedge clk_in) disable iff (!nrst_in)
		s_wr_path |=> synth_ctrl_out.modulator_pd == $past(w_byte[`PATH_MOD_PD_BIT]);
	endproperty
	a_modpd_write: assert property (p_modpd_write) else $error("modulator pd wrong");

	// reset values of the path, pump and filter fields
	property p_reset_vals;
		@(posedge clk_in)
		!nrst_in |-> synth_ctrl_out.modulator_pd && !synth_ctrl_out.doubler_sel &&
			synth_ctrl_out.loop_mode == `MODE_SINGLE;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("path reset wrong");

	property p_pump_reset;
		@(posedge clk_in)
		!nrst_in |-> pump_current == `PUMP_RESET && pump_ua == 10'h234;
	endproperty
	a_pump_reset: assert property (p_pump_reset) else $error("pump reset wrong");

	// current output is four times the code one cycle earlier
	property p_pump_scale;
		@(posedge clk_in) disable iff (!nrst_in)
		##1 pump_ua == {$past(pump_current), 2'b00};
	endproperty
	a_pump_scale: assert property (p_pump_scale) else $error("pump current not 4x");

	property p_filt_reset;
		@(posedge clk_in)
		!nrst_in |-> synth_ctrl_out.zero_resistor_code == 3'h5 &&
			synth_ctrl_out.first_pole_cap_code == 3'h0;
	endproperty
	a_filt_reset: assert property (p_filt_reset) else $error("filter reset wrong");

	// reads of a 4-bit register show zero in the reserved bits
	property p_rsvd_zero;
		@(posedge clk_in) disable iff (!nrst_in)
		ar_fire && (rd_ctl || rd_path) |=> rvalid && rdata[31:4] == 28'h0000000;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

	// a filter write reads back unchanged
	property p_filt_back;
		@(posedge clk_in) disable iff (!nrst_in)
		wr_en && sel_filt |=> loop_filter == $past(w_byte);
	endproperty
	a_filt_back: assert property (p_filt_back) else $error("filter not stored");

endmodule // primary_synth_config_regs

// [bench/primary_synth_config_regs_tb.sv]
// self-checking bench for the primary synth register bank over axi4-lite
`timescale 1ns/1ps
`include "primary_synth_regs.svh"

module primary_synth_config_regs_tb;
	import primary_synth_pkg::*;

	localparam logic [11:0] A_CTL  = {`IDX_LOOP_CONTROL, 2'b00};   // control word
	localparam logic [11:0] A_PATH = {`IDX_PATH_CONFIG, 2'b00};    // path config word
	localparam logic [11:0] A_PUMP = {`IDX_PUMP_CURRENT, 2'b00};   // pump current word
	localparam logic [11:0] A_FILT = {`IDX_LOOP_FILTER, 2'b00};    // loop filter word
	localparam logic [11:0] A_NONE = 12'h420;                      // unmapped index

	logic        clk_in = 1'b0;      // 25 MHz clock
	logic        nrst_in = 1'b1;     // reset, active low; lowered at time zero
	logic [11:0] awaddr = 12'h000;   // write address
	logic        awvalid = 1'b0;     // write address valid
	logic [31:0] wdata = 32'h0;      // write data
	logic [3:0]  wstrb = 4'h0;       // write strobes
	logic        wvalid = 1'b0;      // write data valid
	logic        bready = 1'b0;      // write response ready
	logic [11:0] araddr = 12'h000;   // read address
	logic        arvalid = 1'b0;     // read address valid
	logic        rready = 1'b0;      // read data ready
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;       // response codes
	wire  [31:0] rdata;              // read data
	synth_ctrl_t ctl;                // controls to the loop
	int          n_mismatch = 0;     // mismatches seen
	int          checks = 0;         // comparisons made
	int          n_cal = 0;          // calibration pulses seen

	always #20 clk_in = ~clk_in;

	primary_synth_config_regs DUT (.clk_in(clk_in), .nrst_in(nrst_in),
		.awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
		.wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready),
		.bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
		.araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
		.rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
		.synth_ctrl_out(ctl));

	// count calibration pulses; a level must never add more than one
	always @(posedge clk_in)
		if (ctl.cal_start === 1'b1)
			n_cal <= n_cal + 1;

	// verdict and end of run, also reached from any timeout
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// compare with case equality so an unknown never matches
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// one write: address and data offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		@(posedge clk_in);
		awaddr <= a; awvalid <= 1'b1; wdata <= {24'hffffff, d}; wstrb <= s;
		wvalid <= 1'b1; bready <= 1'b1;
		for (n = 0; n < 30; n++)
		begin
			@(posedge clk_in);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		if (n == 30)
		begin
			n_mismatch++;
			$display("BAD write timeout at %h", a);
			finish_test();
		end
		bready <= 1'b0;
		check("bresp", er, bresp);
	endtask

	// one read with expected data and response
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge clk_in);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (n = 0; n < 30; n++)
		begin
			@(posedge clk_in);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		if (n == 30)
		begin
			n_mismatch++;
			$display("BAD read timeout at %h", a);
			finish_test();
		end
		rready <= 1'b0;
		check("rdata", ed, rdata);
		check("rresp", er, rresp);
	endtask

	// main sequence
	initial
	begin
		logic [7:0] v;
		nrst_in <= 1'b0;
		idle(2);
		nrst_in <= 1'b1;
		idle(1);
		// reset values of every register and the driven fields
		rd(A_CTL, 32'h00, `RESP_OKAY);
		rd(A_PATH, 32'h01, `RESP_OKAY);
		rd(A_PUMP, 32'h8d, `RESP_OKAY);
		rd(A_FILT, 32'he8, `RESP_OKAY);
		check("mod_pd", 1'b1, ctl.modulator_pd);
		check("pump_ua", 32'h234, ctl.pump_ua);
		check("zero", 3'h5, ctl.zero_resistor_code);
		check("pole1", 3'h0, ctl.first_pole_cap_code);
		$display("test reset values done");
		// reserved bits dropped, sync level, byte lane 0 gating
		wr(A_CTL, 8'hf6, 4'h1, `RESP_OKAY);
		rd(A_CTL, 32'h06, `RESP_OKAY);
		check("sync", 1'b1, ctl.dist_sync);
		check("pd", 1'b1, ctl.synth_powerdown);
		check("rst", 1'b0, ctl.synth_reset);
		wr(A_CTL, 8'h00, 4'h1, `RESP_OKAY);
		check("sync", 1'b0, ctl.dist_sync);
		wr(A_CTL, 8'h01, 4'h1, `RESP_OKAY);
		check("rst", 1'b1, ctl.synth_reset);
		check("pd", 1'b0, ctl.synth_powerdown);
		wr(A_CTL, 8'h0f, 4'h0, `RESP_OKAY);
		rd(A_CTL, 32'h01, `RESP_OKAY);
		$display("test control bits done");
		// calibration starts only on a rising edge of the bit
		wr(A_CTL, 8'h08, 4'h1, `RESP_OKAY);
		idle(4);
		wr(A_CTL, 8'h08, 4'h1, `RESP_OKAY);
		idle(4);
		check("cal count", 1, n_cal);
		wr(A_CTL, 8'h00, 4'h1, `RESP_OKAY);
		wr(A_CTL, 8'h08, 4'h1, `RESP_OKAY);
		idle(4);
		check("cal count", 2, n_cal);
		$display("test calibration done");
		// every loop mode with both input paths, modulator enabled
		for (int i = 0; i < 8; i++)
		begin
			wr(A_PATH, {4'hf, i[0], i[2:1], 1'b0}, 4'h1, `RESP_OKAY);
			rd(A_PATH, {28'h0, i[0], i[2:1], 1'b0}, `RESP_OKAY);
			check("mode", i[2:1], ctl.loop_mode);
			check("dbl", i[0], ctl.doubler_sel);
			check("mod_pd", 1'b0, ctl.modulator_pd);
		end
		$display("test path config done");
		// pump code boundaries and the four-times current
		for (int i = 0; i < 4; i++)
		begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'h01 : 8'h80;
			wr(A_PUMP, v, 4'h1, `RESP_OKAY);
			idle(1);
			check("pump", v, ctl.pump_code);
			check("pump_ua", {v, 2'b00}, ctl.pump_ua);
			rd(A_PUMP, {24'h0, v}, `RESP_OKAY);
		end
		$display("test pump current done");
		// every resistor and capacitor code
		for (int i = 0; i < 8; i++)
		begin
			v = {i[1:0], i[2:0], 3'h7 - i[2:0]};
			wr(A_FILT, v, 4'h1, `RESP_OKAY);
			rd(A_FILT, {24'h0, v}, `RESP_OKAY);
			check("zero", i[2:0], ctl.zero_resistor_code);
			check("pole1", 3'h7 - i[2:0], ctl.first_pole_cap_code);
			check("pole2", i[1:0], ctl.second_pole_resistor_code);
		end
		$display("test loop filter done");
		// unmapped place refuses and leaves the filter register alone
		wr(A_NONE, 8'h55, 4'h1, `RESP_SLVERR);
		rd(A_NONE, 32'h0, `RESP_SLVERR);
		rd(A_FILT, {24'h0, v}, `RESP_OKAY);
		$display("test unmapped done");
		// a reset in mid-run brings back the reset values
		nrst_in <= 1'b0;
		idle(2);
		nrst_in <= 1'b1;
		idle(1);
		rd(A_PATH, 32'h01, `RESP_OKAY);
		rd(A_FILT, 32'he8, `RESP_OKAY);
		check("pump_ua", 32'h234, ctl.pump_ua);
		$display("test reset again done");
		finish_test();
	end

endmodule // primary_synth_config_regs_tb
